//--- design/hpo_pkg.sv
// Purpose: shared constants and types for the high-current output protection block
// Assumes: 200 MHz system clock, currents in mA
// Notes: register offsets are byte addresses on the plain register port
package hpo_pkg;
   // channel count and data widths
   localparam int NCH = 12;
   localparam int CUR_W = 17;
   localparam int CNT_W = 32;
   localparam int RET_W = 4;
   localparam int SETTLE_W = 14;
   localparam int FUSE_W = 15;
   localparam int IVL_W = 14;
   localparam int ADDR_W = 10;

   // clock rate and times in their own units
   localparam int CLK_MHZ = 200;
   localparam int INRUSH_US = 20;
   localparam int INRUSH_CYC = INRUSH_US * CLK_MHZ;
   localparam int MS_US = 1000;
   localparam int CYC_PER_MS = MS_US * CLK_MHZ;
   localparam int WIN0_US = 150;
   localparam int WIN1_US = 1200;
   localparam int WIN2_US = 10000;
   localparam int WIN3_US = 155000;
   localparam int WIN0_CYC = WIN0_US * CLK_MHZ;
   localparam int WIN1_CYC = WIN1_US * CLK_MHZ;
   localparam int WIN2_CYC = WIN2_US * CLK_MHZ;
   localparam int WIN3_CYC = WIN3_US * CLK_MHZ;
   localparam logic [SETTLE_W-1:0] SETTLE_MAX_MS = 14'h2710;

   // current thresholds in mA
   localparam logic [CUR_W-1:0] PEAK_MA = 17'h186a0;
   localparam logic [CUR_W-1:0] CONT0_MA = 17'h03a98;
   localparam logic [CUR_W-1:0] CONT1_MA = 17'h04e20;
   localparam logic [CUR_W-1:0] CONT2_MA = 17'h061a8;

   // global register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 10'h000;
   localparam logic [ADDR_W-1:0] REG_FCLR = 10'h004;
   localparam logic [ADDR_W-1:0] REG_MAN = 10'h008;
   localparam logic [ADDR_W-1:0] REG_ON = 10'h00c;
   localparam logic [ADDR_W-1:0] REG_FLT = 10'h010;
   // per-channel pages: addr[9:8] page, addr[7:4] channel, addr[3:2] word
   localparam logic [1:0] PAGE_CFG = 2'h1;
   localparam logic [1:0] PAGE_CUR = 2'h2;
   localparam logic [1:0] CFG_SEL = 2'h0;
   localparam logic [1:0] CFG_SETTLE = 2'h1;
   localparam logic [1:0] CFG_FUSE = 2'h2;
   localparam logic [1:0] CFG_IVL = 2'h3;

   // field positions in the select and control words
   localparam int SEL_LIM_LSB = 0;
   localparam int SEL_WIN_LSB = 2;
   localparam int SEL_RET_LSB = 8;
   localparam int CTRL_MAN_BIT = 0;

   // values after reset
   localparam logic [1:0] RST_LIM_SEL = 2'h0;
   localparam logic [1:0] RST_WIN_SEL = 2'h0;
   localparam logic [RET_W-1:0] RST_RETRIES = 4'h3;
   localparam logic [SETTLE_W-1:0] RST_SETTLE_MS = 14'h000a;
   localparam logic [FUSE_W-1:0] RST_FUSE_MA = 15'h0064;
   localparam logic [IVL_W-1:0] RST_IVL_MS = 14'h000a;

   typedef enum logic [3:0] {
      ST_OFF  = 4'h1,
      ST_ON   = 4'h2,
      ST_WAIT = 4'h4,
      ST_LOCK = 4'h8
   } hpo_state_t;
endpackage

//--- design/hpo_sat_cnt.sv
// Purpose: saturating up-counter, one per channel timer
// Assumes: clr_in restarts from zero on the next edge
// Notes: sticks at all-ones so long waits never wrap into a false match
`timescale 1ns/1ps
module hpo_sat_cnt #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control and count
   input wire logic clr_in,
   output logic [W-1:0] cnt_out
);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_out <= '0;
      end else if (clr_in) begin
         cnt_out <= '0;
      end else if (cnt_out != {W{1'b1}}) begin
         cnt_out <= cnt_out + 1'b1;
      end
   end
endmodule

//--- design/hpo_top.sv
// Purpose: protection and switching of twelve high-current outputs
// Assumes: current samples and event requests come from logic on clk_in
// Notes: one timer per channel, restarted on every state change
// Function
// - twelve independent channels, each fully configured
// - ignore peak current during first 20 us
// - after inrush, current at 100 A trips
// - continuous limit selectable 15, 20, 25 A
// - current below continuous limit within window
// - settle delay accepted up to ten seconds
// - after settle, steady fuse exceedance trips
// - automatic re-enable up to retry count
// - retries spaced by interval in milliseconds
// - live current per channel readable in mA
// - manual mode drops events, all channels off
// - manual on command toggles its channel
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module hpo_top #(
   parameter int unsigned CYC_PER_MS = hpo_pkg::CYC_PER_MS,
   parameter int unsigned WIN0_CYC = hpo_pkg::WIN0_CYC,
   parameter int unsigned WIN1_CYC = hpo_pkg::WIN1_CYC,
   parameter int unsigned WIN2_CYC = hpo_pkg::WIN2_CYC,
   parameter int unsigned WIN3_CYC = hpo_pkg::WIN3_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [hpo_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // event-driven demand and measured currents
   input wire logic [hpo_pkg::NCH-1:0] evt_on_in,
   input wire logic [hpo_pkg::NCH*hpo_pkg::CUR_W-1:0] current_ma_in,
   // output stage control and status
   output logic [hpo_pkg::NCH-1:0] ch_on_out,
   output logic [hpo_pkg::NCH-1:0] ch_fault_out
);
   localparam int N = hpo_pkg::NCH;

   logic rst_s1_r;
   logic rst_n_r;
   logic manual_r;
   logic [N-1:0] man_r;
   logic [N-1:0] fclr;
   logic [N-1:0] cfg_wr;
   logic [1:0] lim_sel_r [N];
   logic [1:0] win_sel_r [N];
   logic [hpo_pkg::RET_W-1:0] retries_r [N];
   logic [hpo_pkg::SETTLE_W-1:0] settle_ms_r [N];
   logic [hpo_pkg::FUSE_W-1:0] fuse_ma_r [N];
   logic [hpo_pkg::IVL_W-1:0] ivl_ms_r [N];
   logic [N-1:0] demand;
   logic [3:0] acc_ch;
   logic [1:0] acc_page;
   logic [1:0] acc_word;
   logic acc_ch_ok;
   logic [31:0] rd_val;

   // reset release through two flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   assign acc_page = reg_addr_in[9:8];
   assign acc_ch = reg_addr_in[7:4];
   assign acc_word = reg_addr_in[3:2];
   assign acc_ch_ok = (acc_ch < 4'(N)) && (reg_addr_in[1:0] == 2'h0);

   // mode control
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         manual_r <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == hpo_pkg::REG_CTRL) begin
         manual_r <= reg_wdata_in[hpo_pkg::CTRL_MAN_BIT];
      end
   end

   // manual switch states start off on every mode change
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         man_r <= '0;
      end else if (!manual_r) begin
         man_r <= '0;
      end else if (reg_wr_in && reg_addr_in == hpo_pkg::REG_MAN) begin
         man_r <= man_r ^ reg_wdata_in[N-1:0];
      end
   end

   // manual mode fully replaces event control
   assign demand = manual_r ? man_r : evt_on_in;

   assign fclr = (reg_wr_in && reg_addr_in == hpo_pkg::REG_FCLR) ? reg_wdata_in[N-1:0] : '0;

   // per-channel configuration
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         for (int i = 0; i < N; i++) begin
            lim_sel_r[i] <= hpo_pkg::RST_LIM_SEL;
            win_sel_r[i] <= hpo_pkg::RST_WIN_SEL;
            retries_r[i] <= hpo_pkg::RST_RETRIES;
            settle_ms_r[i] <= hpo_pkg::RST_SETTLE_MS;
            fuse_ma_r[i] <= hpo_pkg::RST_FUSE_MA;
            ivl_ms_r[i] <= hpo_pkg::RST_IVL_MS;
         end
      end else if (reg_wr_in && acc_page == hpo_pkg::PAGE_CFG && acc_ch_ok) begin
         case (acc_word)
            hpo_pkg::CFG_SEL: begin
               lim_sel_r[acc_ch] <= reg_wdata_in[hpo_pkg::SEL_LIM_LSB +: 2];
               win_sel_r[acc_ch] <= reg_wdata_in[hpo_pkg::SEL_WIN_LSB +: 2];
               retries_r[acc_ch] <= reg_wdata_in[hpo_pkg::SEL_RET_LSB +: hpo_pkg::RET_W];
            end
            hpo_pkg::CFG_SETTLE: begin
               // longer requests are held at ten seconds
               if (reg_wdata_in > 32'(hpo_pkg::SETTLE_MAX_MS)) begin
                  settle_ms_r[acc_ch] <= hpo_pkg::SETTLE_MAX_MS;
               end else begin
                  settle_ms_r[acc_ch] <= reg_wdata_in[hpo_pkg::SETTLE_W-1:0];
               end
            end
            hpo_pkg::CFG_FUSE: begin
               fuse_ma_r[acc_ch] <= reg_wdata_in[hpo_pkg::FUSE_W-1:0];
            end
            hpo_pkg::CFG_IVL: begin
               ivl_ms_r[acc_ch] <= reg_wdata_in[hpo_pkg::IVL_W-1:0];
            end
            default: begin
               lim_sel_r[acc_ch] <= lim_sel_r[acc_ch];
            end
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         hpo_pkg::hpo_state_t st_r;
         hpo_pkg::hpo_state_t st_nxt;
         logic [hpo_pkg::CNT_W-1:0] cnt;
         logic [hpo_pkg::CUR_W-1:0] cur;
         logic [hpo_pkg::CUR_W-1:0] lim_ma;
         logic [hpo_pkg::CNT_W-1:0] win_cyc;
         logic [hpo_pkg::CNT_W-1:0] settle_cyc;
         logic [hpo_pkg::CNT_W-1:0] ivl_cyc;
         logic [hpo_pkg::RET_W-1:0] used_r;
         logic past_inrush;
         logic trip;

         assign cur = current_ma_in[g*hpo_pkg::CUR_W +: hpo_pkg::CUR_W];
         assign cfg_wr[g] = reg_wr_in && acc_page == hpo_pkg::PAGE_CFG && acc_ch_ok &&
                            acc_ch == 4'(g);

         always_comb begin
            case (lim_sel_r[g])
               2'h0: lim_ma = hpo_pkg::CONT0_MA;
               2'h1: lim_ma = hpo_pkg::CONT1_MA;
               default: lim_ma = hpo_pkg::CONT2_MA;
            endcase
            case (win_sel_r[g])
               2'h0: win_cyc = WIN0_CYC;
               2'h1: win_cyc = WIN1_CYC;
               2'h2: win_cyc = WIN2_CYC;
               default: win_cyc = WIN3_CYC;
            endcase
         end

         // products stay within 32 bits for the field widths used
         assign settle_cyc = hpo_pkg::CNT_W'(32'(settle_ms_r[g]) * CYC_PER_MS);
         assign ivl_cyc = hpo_pkg::CNT_W'(32'(ivl_ms_r[g]) * CYC_PER_MS);

         assign past_inrush = cnt >= 32'(hpo_pkg::INRUSH_CYC);
         assign trip = st_r == hpo_pkg::ST_ON &&
                       ((past_inrush && cur >= hpo_pkg::PEAK_MA) ||
                        (cnt >= win_cyc && cur >= lim_ma) ||
                        (cnt >= settle_cyc && cur > 17'(fuse_ma_r[g])));

         always_comb begin
            st_nxt = st_r;
            case (st_r)
               hpo_pkg::ST_OFF: begin
                  if (demand[g]) begin
                     st_nxt = hpo_pkg::ST_ON;
                  end
               end
               hpo_pkg::ST_ON: begin
                  if (!demand[g]) begin
                     st_nxt = hpo_pkg::ST_OFF;
                  end else if (trip && used_r < retries_r[g]) begin
                     st_nxt = hpo_pkg::ST_WAIT;
                  end else if (trip) begin
                     st_nxt = hpo_pkg::ST_LOCK;
                  end
               end
               hpo_pkg::ST_WAIT: begin
                  if (!demand[g]) begin
                     st_nxt = hpo_pkg::ST_OFF;
                  end else if (cnt >= ivl_cyc) begin
                     st_nxt = hpo_pkg::ST_ON;
                  end
               end
               hpo_pkg::ST_LOCK: begin
                  // only explicit clearing or new settings release it
                  if (fclr[g] || cfg_wr[g]) begin
                     st_nxt = hpo_pkg::ST_OFF;
                  end
               end
               default: st_nxt = hpo_pkg::ST_OFF;
            endcase
         end

         always_ff @(posedge clk_in or negedge rst_n_r) begin
            if (!rst_n_r) begin
               st_r <= hpo_pkg::ST_OFF;
            end else begin
               st_r <= st_nxt;
            end
         end

         // retries used since the last fresh switch-on
         always_ff @(posedge clk_in or negedge rst_n_r) begin
            if (!rst_n_r) begin
               used_r <= '0;
            end else if (st_r == hpo_pkg::ST_OFF) begin
               used_r <= '0;
            end else if (st_r == hpo_pkg::ST_WAIT && st_nxt == hpo_pkg::ST_ON) begin
               used_r <= used_r + 1'b1;
            end
         end

         // timer restarts on every state change, so on each switch-on
         hpo_sat_cnt #(
            .W(hpo_pkg::CNT_W)
         ) u_tmr (
            .clk_in(clk_in),
            .rst_n_in(rst_n_r),
            .clr_in(st_nxt != st_r),
            .cnt_out(cnt)
         );

         assign ch_on_out[g] = st_r == hpo_pkg::ST_ON;
         assign ch_fault_out[g] = st_r == hpo_pkg::ST_LOCK;

         AST_INRUSH: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (st_r == hpo_pkg::ST_ON && demand[g] && !past_inrush &&
             !(cnt >= win_cyc && cur >= lim_ma) && !(cnt >= settle_cyc && cur > 17'(fuse_ma_r[g])))
            |=> st_r == hpo_pkg::ST_ON)
            else $error("channel tripped inside inrush time");
         AST_PEAK: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (st_r == hpo_pkg::ST_ON && past_inrush && cur >= hpo_pkg::PEAK_MA)
            |=> !ch_on_out[g])
            else $error("peak current did not switch channel off");
         AST_CONT: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (st_r == hpo_pkg::ST_ON && cnt >= win_cyc && cur >= lim_ma) |=> !ch_on_out[g])
            else $error("continuous limit ignored after window");
         AST_FUSE: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (st_r == hpo_pkg::ST_ON && cnt >= settle_cyc && cur > 17'(fuse_ma_r[g]))
            |=> !ch_on_out[g])
            else $error("steady fuse ignored after settle delay");
         AST_RETRY: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (trip && demand[g] && used_r < retries_r[g]) |=> st_r == hpo_pkg::ST_WAIT)
            else $error("retry not taken while retries remain");
         // a retry may only follow a full interval spent off
         AST_SPACING: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (st_r == hpo_pkg::ST_WAIT && demand[g] && cnt < ivl_cyc) |=> !ch_on_out[g])
            else $error("retry came before its interval");
         AST_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (st_r == hpo_pkg::ST_LOCK && !fclr[g] && !cfg_wr[g]) |=> ch_fault_out[g] && !ch_on_out[g])
            else $error("latched fault released without clear");
         AST_RESTART: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            $rose(ch_on_out[g]) |-> cnt == '0)
            else $error("timer not restarted at switch-on");
         AST_EXHAUST: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            (trip && demand[g] && used_r >= retries_r[g]) |=> ch_fault_out[g] && !ch_on_out[g])
            else $error("exhausted channel not latched off");
         AST_DEMAND_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_r)
            !demand[g] |=> !ch_on_out[g])
            else $error("channel on without demand");
      end
   endgenerate

   AST_MAN_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      $rose(manual_r) |-> man_r == '0 ##1 ch_on_out == '0)
      else $error("manual mode did not start with channels off");
   AST_TOGGLE: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (manual_r && reg_wr_in && reg_addr_in == hpo_pkg::REG_MAN && !(reg_wr_in &&
       reg_addr_in == hpo_pkg::REG_CTRL)) |=> man_r == ($past(man_r) ^ $past(reg_wdata_in[N-1:0])))
      else $error("manual command did not toggle");
   AST_CUR: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (reg_rd_in && acc_page == hpo_pkg::PAGE_CUR && acc_ch_ok)
      |=> reg_rdata_out == 32'($past(current_ma_in[acc_ch*hpo_pkg::CUR_W +: hpo_pkg::CUR_W])))
      else $error("current readback wrong");
   AST_RDZERO: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      !reg_rd_in |=> reg_rdata_out == '0)
      else $error("read data outside its answer cycle");

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_val = '0;
      if (acc_page == hpo_pkg::PAGE_CFG && acc_ch_ok) begin
         case (acc_word)
            hpo_pkg::CFG_SEL: begin
               rd_val[hpo_pkg::SEL_LIM_LSB +: 2] = lim_sel_r[acc_ch];
               rd_val[hpo_pkg::SEL_WIN_LSB +: 2] = win_sel_r[acc_ch];
               rd_val[hpo_pkg::SEL_RET_LSB +: hpo_pkg::RET_W] = retries_r[acc_ch];
            end
            hpo_pkg::CFG_SETTLE: rd_val = 32'(settle_ms_r[acc_ch]);
            hpo_pkg::CFG_FUSE: rd_val = 32'(fuse_ma_r[acc_ch]);
            default: rd_val = 32'(ivl_ms_r[acc_ch]);
         endcase
      end else if (acc_page == hpo_pkg::PAGE_CUR && acc_ch_ok) begin
         rd_val = 32'(current_ma_in[acc_ch*hpo_pkg::CUR_W +: hpo_pkg::CUR_W]);
      end else begin
         case (reg_addr_in)
            hpo_pkg::REG_CTRL: rd_val[hpo_pkg::CTRL_MAN_BIT] = manual_r;
            hpo_pkg::REG_MAN: rd_val[N-1:0] = man_r;
            hpo_pkg::REG_ON: rd_val[N-1:0] = ch_on_out;
            hpo_pkg::REG_FLT: rd_val[N-1:0] = ch_fault_out;
            default: rd_val = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_val;
      end else begin
         reg_rdata_out <= '0;
      end
   end
endmodule

//--- test/hpo_load_model.sv
// Purpose: load side of the twelve switch stages, turns switch drive into sensed current
// Assumes: loads are steady, set per channel by the bench
// Notes: purely combinational, the block's switch drive comes from flops
`timescale 1ns/1ps
module hpo_load_model (
   // switch drive from the block
   input wire logic [hpo_pkg::NCH-1:0] ch_on_in,
   // current each load draws while its switch is closed
   input wire logic [hpo_pkg::NCH*hpo_pkg::CUR_W-1:0] load_ma_in,
   // sensed currents back to the block
   output logic [hpo_pkg::NCH*hpo_pkg::CUR_W-1:0] current_ma_out
);
   // an open switch carries nothing, so an off channel never shows a stale load
   always_comb begin
      for (int i = 0; i < hpo_pkg::NCH; i++) begin
         current_ma_out[i*hpo_pkg::CUR_W +: hpo_pkg::CUR_W] =
            ch_on_in[i] ? load_ma_in[i*hpo_pkg::CUR_W +: hpo_pkg::CUR_W] : '0;
      end
   end
endmodule

//--- test/high_power_output_protection_bench.sv
// Purpose: register-level regression of the output protection block
// Assumes: shortened timers, 20 cycles a millisecond
// Notes: load currents come from the load model, events from the bench
`timescale 1ns/1ps
module high_power_output_protection_bench;
   logic clk_in, rst_n_in, reg_wr_in, reg_rd_in;
   logic [hpo_pkg::ADDR_W-1:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, rd_v;
   logic [hpo_pkg::NCH-1:0] evt_on_in, ch_on_out, ch_fault_out;
   logic [hpo_pkg::NCH*hpo_pkg::CUR_W-1:0] current_ma_in, load_ma;
   int n_fail, compares;
   int lims[4] = '{15000, 20000, 25000, 25000};
   int wins[4] = '{30, 60, 100, 8000};

   hpo_top #(.CYC_PER_MS(20), .WIN0_CYC(30), .WIN1_CYC(60), .WIN2_CYC(100),
      .WIN3_CYC(8000)) u_hpo_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .evt_on_in(evt_on_in),
      .current_ma_in(current_ma_in), .ch_on_out(ch_on_out), .ch_fault_out(ch_fault_out));
   hpo_load_model u_hpo_load_model (.ch_on_in(ch_on_out), .load_ma_in(load_ma),
      .current_ma_out(current_ma_in));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   function automatic logic [9:0] ca(input int pg, input int ch, input int w);
      return 10'(pg * 256 + ch * 16 + w * 4);
   endfunction

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      rd_v = reg_rdata_out;
      chk(what, exp, rd_v);
   endtask

   task automatic cfg(input int ch, input int sel, input int st, input int fu, input int iv);
      wr(ca(1, ch, 0), 32'(sel));
      wr(ca(1, ch, 1), 32'(st));
      wr(ca(1, ch, 2), 32'(fu));
      wr(ca(1, ch, 3), 32'(iv));
   endtask

   task automatic drv(input int ch, input logic ev, input int ma);
      @(posedge clk_in);
      evt_on_in[ch] <= ev;
      load_ma[ch*hpo_pkg::CUR_W +: hpo_pkg::CUR_W] <= 17'(ma);
   endtask

   initial begin
      repeat (40000) @(posedge clk_in);
      n_fail++;
      stop_test();
   end

   initial begin
      n_fail = 0;
      compares = 0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = '0;
      reg_wdata_in = '0;
      evt_on_in = '0;
      load_ma = '0;
      rst_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      wt(1);
      chk("on after reset", 32'h0, 32'(ch_on_out));
      chk("fault after reset", 32'h0, 32'(ch_fault_out));
      wt(4);
      for (int c = 0; c < 12; c += 11) begin
         rdc(ca(1, c, 0), 32'h0000_0300, "select word");
         rdc(ca(1, c, 1), 32'h0000_000a, "settle delay");
         rdc(ca(1, c, 2), 32'h0000_0064, "fuse level");
         rdc(ca(1, c, 3), 32'h0000_000a, "interval");
      end
      rdc(10'h3fc, 32'h0, "unmapped read");
      rdc(ca(1, 12, 0), 32'h0, "channel 12 read");
      // below both limits, so channel 0 must stay on until manual mode switches it off
      cfg(0, 0, 100, 14000, 10);
      drv(0, 1'b1, 5000);
      wt(2);
      chk("ch0 on", 32'h1, 32'(ch_on_out[0]));
      rdc(ca(2, 0, 0), 32'd5000, "live current");
      // peak limit: tolerated through the inrush span, then a trip with no retry
      cfg(1, 32'he, 10000, 24000, 10);
      drv(1, 1'b1, 100000);
      wt(4000);
      chk("ch1 in inrush", 32'h1, 32'(ch_on_out[1]));
      wt(2);
      chk("ch1 after inrush", 32'h0, 32'(ch_on_out[1]));
      rdc(hpo_pkg::REG_FLT, 32'h2, "fault register");
      drv(1, 1'b0, 0);
      wr(ca(1, 1, 1), 32'd12000);
      rdc(ca(1, 1, 1), 32'd10000, "settle clamp");
      chk("ch1 fault after config", 32'h0, 32'(ch_fault_out[1]));
      // every limit and window code, with the load sitting exactly on the limit
      for (int k = 0; k < 4; k++) begin
         cfg(2, k * 5, 10000, 14000, 10);
         drv(2, 1'b1, lims[k]);
         wt(wins[k] - 2);
         chk("ch2 within window", 32'h1, 32'(ch_on_out[2]));
         wt(5);
         chk("ch2 after window", 32'h0, 32'(ch_on_out[2]));
         chk("ch2 latched", 32'h1, 32'(ch_fault_out[2]));
         drv(2, 1'b0, 0);
         wr(hpo_pkg::REG_FCLR, 32'h4);
         wt(2);
         chk("ch2 cleared", 32'h0, 32'(ch_fault_out[2]));
      end
      // steady fuse after 40 cycles, two retries spaced by 60 cycles
      cfg(3, 32'h202, 2, 1000, 3);
      drv(3, 1'b1, 1001);
      wt(20);
      chk("ch3 settling", 32'h1, 32'(ch_on_out[3]));
      wt(30);
      chk("ch3 fused", 32'h0, 32'(ch_on_out[3]));
      chk("ch3 no lock", 32'h0, 32'(ch_fault_out[3]));
      wt(52);
      chk("ch3 waiting", 32'h0, 32'(ch_on_out[3]));
      wt(1);
      chk("ch3 retried", 32'h1, 32'(ch_on_out[3]));
      wt(147);
      chk("ch3 exhausted", 32'h0, 32'(ch_on_out[3]));
      chk("ch3 locked", 32'h1, 32'(ch_fault_out[3]));
      wt(100);
      chk("ch3 stays off", 32'h0, 32'(ch_on_out[3]));
      drv(3, 1'b0, 0);
      wr(hpo_pkg::REG_FCLR, 32'h8);
      wt(2);
      chk("ch3 cleared", 32'h0, 32'(ch_fault_out[3]));
      // manual mode overrides the still-raised event on channel 0
      chk("ch0 still on", 32'h1, 32'(ch_on_out[0]));
      wr(hpo_pkg::REG_CTRL, 32'h1);
      wt(3);
      chk("manual all off", 32'h0, 32'(ch_on_out));
      wr(hpo_pkg::REG_MAN, 32'h10);
      wt(3);
      chk("manual toggle on", 32'h10, 32'(ch_on_out));
      rdc(hpo_pkg::REG_MAN, 32'h10, "manual states");
      rdc(hpo_pkg::REG_ON, 32'h10, "on register");
      wr(hpo_pkg::REG_MAN, 32'h10);
      wt(3);
      chk("manual toggle off", 32'h0, 32'(ch_on_out));
      wr(hpo_pkg::REG_CTRL, 32'h0);
      wt(3);
      chk("events back", 32'h1, 32'(ch_on_out));
      stop_test();
   end
endmodule
